/* File: src/option_config_bank.v */
/*
 * Write-once option configuration bank on a classic Wishbone slave,
 * with the option outputs, watchdog timer, stop control, auto-wakeup
 * interval and stop recovery delay that the options steer.
 * Assumes clk_i is the oscillator output clock, por_i and rst_i are
 * synchronous to it, and wakeup_tick_i comes from a separate oscillator.
 * Limitation: a wakeup tick that rises in the first stop cycle is lost,
 * since the wakeup counter is still being cleared then.
 * Writes are decoded on the taking edge, so a stored value is already
 * visible in the cycle in which ack is high.
 * Trip mode and reset-pin function survive every reset but power-on.
 */
// Added by the designer: register access over Wishbone and the address map.
`default_nettype none
`include "option_config_consts.vh"
module option_config_bank #(
    parameter [17:0] WD_SHORT = `WD_SHORT_CYCLES,
    parameter [17:0] WD_LONG = `WD_LONG_CYCLES,
    parameter [14:0] WAKE_SHORT = `WAKE_SHORT_TICKS,
    parameter [14:0] WAKE_LONG = `WAKE_LONG_TICKS,
    parameter [12:0] REC_SHORT = `REC_SHORT_CYCLES,
    parameter [12:0] REC_LONG = `REC_LONG_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    input wire por_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // core side
    input wire stop_req_i,
    input wire wake_req_i,
    input wire wdog_clear_i,
    input wire wakeup_tick_i,
    input wire undervolt_trip_i,
    output reg illegal_opcode_o,
    output reg stop_mode_o,
    output reg cpu_run_o,
    output reg wdog_reset_o,
    output reg undervolt_reset_o,
    output reg undervolt_power_on_o,
    output reg undervolt_trip_mode_o,
    output reg irq_pullup_on_o,
    output reg irq_pin_function_on_o,
    output reg [1:0] osc_source_sel_o,
    output reg reset_pin_function_on_o,
    output reg wdog_enabled_o
);
    // stop sequencing states
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_STOP = 2'h1;
    localparam [1:0] ST_RECOVER = 2'h2;

    reg [7:0] option_config_one;
    reg [7:0] option_config_two;
    reg one_written;
    reg two_written;
    reg [1:0] state;
    reg [1:0] next_state;
    reg rec_load;
    reg rec_long;
    reg wake_load;

    wire sel_one;
    wire sel_two;
    wire wr_one;
    wire wr_two;
    wire bus_req;
    wire tick_rise;
    wire trip_level;
    wire trip_rise;
    wire wd_done;
    wire wake_done;
    wire rec_done;
    wire [17:0] wd_period;
    wire [14:0] wake_period;
    wire [12:0] rec_period;

    // field views of the first register
    wire watchdog_period_sel = option_config_one[`OPT_WD_PERIOD_BIT];
    wire undervolt_stop_enable = option_config_one[`OPT_UV_STOP_BIT];
    wire undervolt_reset_disable = option_config_one[`OPT_UV_RSTD_BIT];
    wire undervolt_power_disable = option_config_one[`OPT_UV_PWRD_BIT];
    wire undervolt_trip_mode = option_config_one[`OPT_UV_TRIP_BIT];
    wire short_stop_recovery = option_config_one[`OPT_SHORT_REC_BIT];
    wire stop_enable = option_config_one[`OPT_STOP_EN_BIT];
    wire watchdog_disable = option_config_one[`OPT_WD_DIS_BIT];

    // field views of the second register
    wire irq_pin_pullup_off = option_config_two[`OPT_PULLUP_OFF_BIT];
    wire irq_pin_function_on = option_config_two[`OPT_IRQ_ON_BIT];
    wire osc_source_sel_hi = option_config_two[`OPT_OSC_HI_BIT];
    wire osc_source_sel_lo = option_config_two[`OPT_OSC_LO_BIT];
    wire reset_pin_function_on = option_config_two[`OPT_RST_PIN_BIT];

    // address decode; one word per register, data in lane 0
    assign bus_req = cyc_i & stb_i & ~ack_o;
    // registers sit one word apart; the two low address bits are ignored
    assign sel_one = adr_i[7:2] == `OPT_ONE_INDEX; // R02
    assign sel_two = adr_i[7:2] == `OPT_TWO_INDEX; // R02
    // a write without lane 0 stores nothing and does not use up the write
    assign wr_one = bus_req & we_i & sel_i[0] & sel_one & ~one_written; // R01 R19
    assign wr_two = bus_req & we_i & sel_i[0] & sel_two & ~two_written; // R01 R19

    // bus answer: one wait state, ack dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    // read data stands only with ack; zero otherwise keeps the bus quiet
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            dat_o <= 32'h00000000;
        end else if (bus_req & ~we_i & sel_one) begin
            dat_o <= {24'h000000, option_config_one}; // R02
        end else if (bus_req & ~we_i & sel_two) begin
            dat_o <= {24'h000000, option_config_two}; // R02
        end else begin
            dat_o <= 32'h00000000;
        end
    end

    // first register; trip mode survives all but power-on reset
    always @(posedge clk_i) begin
        if (por_i) begin
            option_config_one <= `OPT_ONE_RESET; // R13
            one_written <= 1'b0;
        end else if (rst_i) begin
            // clear all fields, then hold the trip mode bit over the clear
            option_config_one <= `OPT_ONE_RESET; // R03
            option_config_one[`OPT_UV_TRIP_BIT] <= option_config_one[`OPT_UV_TRIP_BIT]; // R13
            one_written <= 1'b0; // R01
        end else if (wr_one) begin
            option_config_one <= dat_i[7:0]; // R01
            one_written <= 1'b1; // R19
        end
    end

    // second register; reset-pin function survives all but power-on reset
    always @(posedge clk_i) begin
        if (por_i) begin
            option_config_two <= `OPT_TWO_RESET; // R07
            two_written <= 1'b0;
        end else if (rst_i) begin
            // clear all fields, then hold the reset-pin bit over the clear
            option_config_two <= `OPT_TWO_RESET; // R03
            option_config_two[`OPT_RST_PIN_BIT] <= option_config_two[`OPT_RST_PIN_BIT]; // R07
            two_written <= 1'b0; // R01
        end else if (wr_two) begin
            option_config_two <= dat_i[7:0]; // R01
            two_written <= 1'b1; // R19
        end
    end

    // wakeup oscillator and undervolt comparator are foreign to clk_i
    edge_sync u_tick_sync (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .async_i(wakeup_tick_i),
        .level_o(),
        .rise_o(tick_rise)
    );

    // undervolt trip level, edge-detected as well for requests outside stop (run or recovery)
    edge_sync u_trip_sync (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .async_i(undervolt_trip_i),
        .level_o(trip_level),
        .rise_o(trip_rise)
    );

    // period selections
    assign wd_period = watchdog_period_sel ? WD_SHORT : WD_LONG; // R08
    assign wake_period = watchdog_period_sel ? WAKE_SHORT : WAKE_LONG; // R09
    assign rec_period = rec_long ? REC_LONG : REC_SHORT; // R14

    // watchdog: free running, cleared by software, held at zero in stop, frozen in recovery
    interval_timer #(
        .WIDTH(18)
    ) u_wdog (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .load_i(wdog_clear_i | (state == ST_STOP) | watchdog_disable), // R18 R17
        .count_i(state == ST_RUN), // R08
        .period_i(wd_period),
        .done_o(wd_done)
    );

    // auto-wakeup counts wakeup ticks, from zero at each stop entry
    interval_timer #(
        .WIDTH(15)
    ) u_wake (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .load_i(wake_load),
        .count_i(tick_rise & (state == ST_STOP)), // R09
        .period_i(wake_period),
        .done_o(wake_done)
    );

    // stop recovery delay before the processor runs again
    interval_timer #(
        .WIDTH(13)
    ) u_recover (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .load_i(rec_load),
        .count_i(state == ST_RECOVER),
        .period_i(rec_period),
        .done_o(rec_done)
    );

    // undervolt reset request while powered and not suppressed
    wire uv_powered = ~undervolt_power_disable &
        ((state != ST_STOP) | undervolt_stop_enable); // R10 R12
    wire uv_reset_now = trip_level & uv_powered & ~undervolt_reset_disable; // R11

    // stop sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (stop_req_i & stop_enable) begin // R16
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (uv_reset_now | wake_done | wake_req_i) begin
                    next_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (rec_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // state and timer loads
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            state <= ST_RUN;
            rec_load <= 1'b1;
            wake_load <= 1'b1;
        end else begin
            state <= next_state;
            wake_load <= (state == ST_RUN) & (next_state == ST_STOP);
            rec_load <= (state == ST_STOP) & (next_state == ST_RECOVER);
        end
    end

    // recovery length, latched at the stop exit so a later change cannot cut it
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            rec_long <= 1'b1;
        end else if ((state == ST_STOP) & (next_state == ST_RECOVER)) begin
            // an undervolt reset exit must not take the short path
            rec_long <= uv_reset_now | ~short_stop_recovery; // R15 R14
        end
    end

    // refused stop instruction
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            illegal_opcode_o <= 1'b0;
        end else begin
            illegal_opcode_o <= stop_req_i & ~stop_enable & (state == ST_RUN); // R16
        end
    end

    // watchdog overflow; the disable also keeps the timer loaded
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            wdog_reset_o <= 1'b0;
        end else begin
            wdog_reset_o <= wd_done & ~watchdog_disable; // R18 R17
        end
    end

    // undervolt request: a new trip outside stop (run or recovery), or any trip level in stop
    always @(posedge clk_i) begin
        if (rst_i | por_i) begin
            undervolt_reset_o <= 1'b0;
        end else begin
            undervolt_reset_o <= uv_reset_now & (trip_rise | (state == ST_STOP)); // R11
        end
    end

    // run and stop status
    always @(posedge clk_i) begin
        if (por_i) begin
            stop_mode_o <= 1'b0;
            cpu_run_o <= 1'b0;
        end else begin
            stop_mode_o <= (state == ST_STOP);
            cpu_run_o <= ~rst_i & (state == ST_RUN); // R14
        end
    end

    // undervolt controls follow the stored fields; power also drops in stop without undervolt_stop_enable
    always @(posedge clk_i) begin
        if (por_i) begin
            undervolt_power_on_o <= 1'b0;
            undervolt_trip_mode_o <= 1'b0;
        end else begin
            undervolt_power_on_o <= uv_powered; // R12 R10
            undervolt_trip_mode_o <= undervolt_trip_mode; // R13
        end
    end

    // pin options take no warm reset; they follow the stored bits, of which only the reset-pin bit holds
    always @(posedge clk_i) begin
        if (por_i) begin
            irq_pullup_on_o <= 1'b0;
            irq_pin_function_on_o <= 1'b0;
            osc_source_sel_o <= `OSC_INTERNAL;
            reset_pin_function_on_o <= 1'b0;
        end else begin
            irq_pullup_on_o <= ~irq_pin_pullup_off; // R04
            irq_pin_function_on_o <= irq_pin_function_on; // R05
            osc_source_sel_o <= {osc_source_sel_hi, osc_source_sel_lo}; // R06
            reset_pin_function_on_o <= reset_pin_function_on; // R07
        end
    end

    // watchdog enable as seen by the reset logic
    always @(posedge clk_i) begin
        if (por_i) begin
            wdog_enabled_o <= 1'b0;
        end else begin
            wdog_enabled_o <= ~watchdog_disable; // R17
        end
    end
endmodule // option_config_bank
`default_nettype wire

/* File: src/option_config_consts.vh */
/*
 * Constants for the write-once option configuration bank: register
 * indices, field positions, reset values and cycle counts.
 * Assumes it is included by bare name from files under src/.
 */
// Function
// R01: each configuration register takes one software write per reset, then holds
// R02: two consecutive byte addresses, readable at any time; the code puts them one word apart, first at 0x7c, second at 0x78
// R03: reset clears most fields; software should configure right after reset
// R04: irq pullup field 0 connects pullup, 1 disconnects it
// R05: irq function field 1 enables external interrupt on its pin
// R06: oscillator field 00 internal, 01 external, 10 rc, 11 crystal
// R07: reset-pin function field 1 enables; only power-on reset clears it
// R08: watchdog period field 1 gives 8176 cycles, 0 gives 262128
// R09: in stop, period field 1 gives 2^9 wakeup ticks, 0 gives 2^14
// R10: undervolt stays on in stop when stop enable set and power enabled
// R11: undervolt reset disable field 1 suppresses its reset request
// R12: undervolt power disable field 1 powers the inhibit down
// R13: trip mode 1 is 5 V, 0 is 3 V; only power-on reset clears
// R14: short recovery 1 leaves stop after 32 cycles, 0 after 4096
// R15: stop exit by undervolt reset always uses the long recovery
// R16: stop enable 1 allows stop; 0 makes stop an illegal opcode
// R17: watchdog disable 1 turns the watchdog off
// R18: free-running watchdog resets on overflow unless software clears it
// R19: writes after the first since reset are ignored
`ifndef OPTION_CONFIG_CONSTS_VH
`define OPTION_CONFIG_CONSTS_VH

// register indices, byte address is four times the index
`define OPT_TWO_INDEX 6'h1e
`define OPT_ONE_INDEX 6'h1f

// second register fields
`define OPT_PULLUP_OFF_BIT 7
`define OPT_IRQ_ON_BIT 6
`define OPT_OSC_HI_BIT 4
`define OPT_OSC_LO_BIT 3
`define OPT_RST_PIN_BIT 0

// first register fields
`define OPT_WD_PERIOD_BIT 7
`define OPT_UV_STOP_BIT 6
`define OPT_UV_RSTD_BIT 5
`define OPT_UV_PWRD_BIT 4
`define OPT_UV_TRIP_BIT 3
`define OPT_SHORT_REC_BIT 2
`define OPT_STOP_EN_BIT 1
`define OPT_WD_DIS_BIT 0

// reset values
`define OPT_TWO_RESET 8'h00
`define OPT_ONE_RESET 8'h00

// oscillator source codes
`define OSC_INTERNAL 2'h0
`define OSC_EXTERNAL 2'h1
`define OSC_EXT_RC 2'h2
`define OSC_CRYSTAL 2'h3

// cycle counts
`define WD_SHORT_CYCLES 18'h01ff0
`define WD_LONG_CYCLES 18'h3fff0
`define WAKE_SHORT_TICKS 15'h0200
`define WAKE_LONG_TICKS 15'h4000
`define REC_SHORT_CYCLES 13'h0020
`define REC_LONG_CYCLES 13'h1000

`endif

/* File: src/edge_sync.v */
/*
 * Two-flop synchroniser with a rising-edge pulse behind it.
 * Assumes the input is asynchronous to clk_i.
 */
`default_nettype none
module edge_sync (
    input wire clk_i,
    input wire rst_i,
    input wire async_i,
    output reg level_o,
    output reg rise_o
);
    reg meta;
    reg level_d;

    // first flop feeds only the second; the edge is taken behind the pair
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            level_o <= 1'b0;
            level_d <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta <= async_i;
            level_o <= meta;
            level_d <= level_o;
            rise_o <= level_o & ~level_d;
        end
    end
endmodule // edge_sync
`default_nettype wire

/* File: src/interval_timer.v */
/*
 * Up counter that pulses done_o once count_i has been seen period_i
 * times since the last load. Assumes period_i is at least one.
 */
`default_nettype none
module interval_timer #(
    parameter WIDTH = 18
) (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire count_i,
    input wire [WIDTH-1:0] period_i,
    output reg done_o
);
    reg [WIDTH-1:0] cnt;

    // load wins over counting so a restart is never lost
    always @(posedge clk_i) begin
        if (rst_i | load_i) begin
            cnt <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end else if (count_i && cnt == period_i - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            cnt <= {WIDTH{1'b0}};
            done_o <= 1'b1;
        end else begin
            cnt <= cnt + {{(WIDTH-1){1'b0}}, count_i};
            done_o <= 1'b0;
        end
    end
endmodule // interval_timer
`default_nettype wire

/* File: dv/option_config_monitor.sv */
/*
 * Checker for the option configuration bank: bus handshake and option pins
 * tied to the register contents seen on reads.
 * Assumes a classic single-cycle master that holds the request until ack.
 */
`default_nettype none
module option_config_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic stop_req_i,
    input wire logic illegal_opcode_o,
    input wire logic stop_mode_o,
    input wire logic wdog_reset_o,
    input wire logic wdog_enabled_o,
    input wire logic undervolt_power_on_o,
    input wire logic undervolt_trip_mode_o,
    input wire logic irq_pullup_on_o,
    input wire logic irq_pin_function_on_o,
    input wire logic [1:0] osc_source_sel_o,
    input wire logic reset_pin_function_on_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_two;
    logic rd_one;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    // read answers, where read data must agree with the option pins
    assign rd_two = ack_o && !we_i && adr_i == 8'h78;
    assign rd_one = ack_o && !we_i && adr_i == 8'h7c;
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    pullup_sense_a: assert property (rd_two |-> irq_pullup_on_o != dat_o[7])
        else $error("pullup pin disagrees with stored field");
    irq_function_a: assert property (rd_two |-> irq_pin_function_on_o == dat_o[6])
        else $error("irq function pin disagrees with stored field");
    osc_select_a: assert property (rd_two |-> osc_source_sel_o == dat_o[4:3])
        else $error("oscillator select disagrees with stored field");
    reset_pin_a: assert property (rd_two |-> reset_pin_function_on_o == dat_o[0])
        else $error("reset pin function disagrees with stored field");
    undervolt_pins_a: assert property (rd_one |->
        undervolt_power_on_o != dat_o[4] && undervolt_trip_mode_o == dat_o[3])
        else $error("undervolt pins disagree with stored fields");
    wdog_enable_a: assert property (rd_one |-> wdog_enabled_o != dat_o[0])
        else $error("watchdog enable disagrees with stored field");
    wdog_off_a: assert property (wdog_reset_o |-> $past(wdog_enabled_o))
        else $error("watchdog reset while disabled");
    illegal_cause_a: assert property (illegal_opcode_o |-> $past(stop_req_i) && !stop_mode_o)
        else $error("illegal opcode without a refused stop");
    cover property (rd_one);
    cover property (illegal_opcode_o);
    cover property (wdog_reset_o);
    cover property (stop_mode_o);
endmodule // option_config_monitor
`default_nettype wire

/* File: dv/tb.sv */
/*
 * Self-checking bench for the option configuration bank: write-once runs
 * over all oscillator codes, resets of both kinds, watchdog and stop.
 * Assumes shortened timer parameters and the checker bound below.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, por_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0] adr_i, v1, v2, e1, e2, pin_vec;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic stop_req_i, wdog_clear_i, wakeup_tick_i, illegal_opcode_o, stop_mode_o;
    logic cpu_run_o, wdog_reset_o, undervolt_reset_o, undervolt_power_on_o;
    logic undervolt_trip_mode_o, irq_pullup_on_o, irq_pin_function_on_o;
    logic reset_pin_function_on_o, wdog_enabled_o;
    logic [1:0] osc_source_sel_o;
    logic wake_req_i, undervolt_trip_i, seen;
    logic [31:0] seed = 32'h00007300;
    int err_count = 0;
    int total_checks = 0;
    int n;
    // option pins gathered in one vector
    assign pin_vec = {irq_pullup_on_o, irq_pin_function_on_o, osc_source_sel_o,
        reset_pin_function_on_o, undervolt_power_on_o, undervolt_trip_mode_o, wdog_enabled_o};
    option_config_bank #(.WD_SHORT(18'h10), .WD_LONG(18'h28), .WAKE_SHORT(15'h4),
        .REC_SHORT(13'h4), .REC_LONG(13'hc)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .stop_req_i(stop_req_i), .wake_req_i(wake_req_i),
        .wdog_clear_i(wdog_clear_i), .wakeup_tick_i(wakeup_tick_i),
        .undervolt_trip_i(undervolt_trip_i), .illegal_opcode_o(illegal_opcode_o),
        .stop_mode_o(stop_mode_o), .cpu_run_o(cpu_run_o), .wdog_reset_o(wdog_reset_o),
        .undervolt_reset_o(undervolt_reset_o), .undervolt_power_on_o(undervolt_power_on_o),
        .undervolt_trip_mode_o(undervolt_trip_mode_o), .irq_pullup_on_o(irq_pullup_on_o),
        .irq_pin_function_on_o(irq_pin_function_on_o), .osc_source_sel_o(osc_source_sel_o),
        .reset_pin_function_on_o(reset_pin_function_on_o), .wdog_enabled_o(wdog_enabled_o));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // pins expected from the two stored bytes
    function automatic logic [7:0] pins(input logic [7:0] o1, input logic [7:0] o2);
        return {~o2[7], o2[6], o2[4:3], o2[0], ~o1[4], o1[3], ~o1[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // non-power-on reset keeps the trip mode and reset pin bits
    task automatic do_reset(input logic p);
        rst_i <= 1'b1;
        por_i <= p;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        e1 = p ? 8'h00 : e1 & 8'h08;
        e2 = p ? 8'h00 : e2 & 8'h01;
        @(posedge clk_i);
    endtask
    // one classic cycle; holds everything until ack is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        chk(32'(ack_o), 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 4'hf, 8'h00);
        chk(q, {24'h0, exp});
    endtask
    task automatic stop_pulse();
        stop_req_i <= 1'b1;
        @(posedge clk_i);
        stop_req_i <= 1'b0;
        n = 0;
        while (illegal_opcode_o !== 1'b1 && stop_mode_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {cyc_i, stb_i, we_i, stop_req_i, wdog_clear_i, wakeup_tick_i} = 6'h00;
        {wake_req_i, undervolt_trip_i} = 2'h0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        do_reset(1'b1);
        rd(8'h78, 8'h00);
        rd(8'h7c, 8'h00);
        rd(8'h40, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v1 = (rnd() | 8'h01) & 8'hfd; // watchdog off, stop refused
            v2 = rnd();
            v2[4:3] = i[1:0];
            bus(1'b1, 8'h7c, 4'he, v1);
            rd(8'h7c, e1);
            bus(1'b1, 8'h7c, 4'hf, v1);
            bus(1'b1, 8'h7c, 4'hf, ~v1);
            bus(1'b1, 8'h78, 4'h1, v2);
            bus(1'b1, 8'h78, 4'h1, ~v2);
            e1 = v1;
            e2 = v2;
            rd(8'h7c, e1);
            rd(8'h78, e2);
            chk({24'h0, pin_vec}, {24'h0, pins(e1, e2)});
            stop_pulse();
            chk(32'({illegal_opcode_o, stop_mode_o}), 32'h2);
            do_reset(i[0]);
            rd(8'h7c, e1);
            rd(8'h78, e2);
        end
        // watchdog on with the short period
        bus(1'b1, 8'h7c, 4'h1, 8'h80);
        wdog_clear_i <= 1'b1;
        @(posedge clk_i);
        wdog_clear_i <= 1'b0;
        n = 0;
        while (wdog_reset_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n >= 12 && n <= 20), 32'h1);
        repeat (10) begin
            wdog_clear_i <= 1'b1;
            @(posedge clk_i);
            wdog_clear_i <= 1'b0;
            repeat (7) begin
                @(posedge clk_i);
                chk(32'(wdog_reset_o), 32'h0);
            end
        end
        // stop allowed, short wakeup and short recovery
        do_reset(1'b0);
        bus(1'b1, 8'h7c, 4'h1, 8'h87);
        stop_pulse();
        chk(32'(stop_mode_o), 32'h1);
        n = 0;
        while (cpu_run_o !== 1'b1 && n < 300) begin
            wakeup_tick_i <= n[1];
            @(posedge clk_i);
            n++;
        end
        wakeup_tick_i <= 1'b0;
        // four ticks of four clocks, sync delay, then the short recovery only
        chk(32'({cpu_run_o, stop_mode_o, n >= 20 && n <= 30}), 32'h5);
        // undervolt trip in stop: long recovery despite the short setting
        do_reset(1'b0);
        bus(1'b1, 8'h7c, 4'h1, 8'hc7);
        stop_pulse();
        undervolt_trip_i <= 1'b1;
        seen = 1'b0;
        n = 0;
        while (cpu_run_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            seen = seen | (undervolt_reset_o === 1'b1);
            n++;
        end
        undervolt_trip_i <= 1'b0;
        chk(32'({seen, n >= 16 && n <= 24}), 32'h3);
        tally_and_finish();
    end
endmodule // tb
bind option_config_bank option_config_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .stop_req_i(stop_req_i),
    .illegal_opcode_o(illegal_opcode_o), .stop_mode_o(stop_mode_o),
    .wdog_reset_o(wdog_reset_o), .wdog_enabled_o(wdog_enabled_o),
    .undervolt_power_on_o(undervolt_power_on_o),
    .undervolt_trip_mode_o(undervolt_trip_mode_o), .irq_pullup_on_o(irq_pullup_on_o),
    .irq_pin_function_on_o(irq_pin_function_on_o), .osc_source_sel_o(osc_source_sel_o),
    .reset_pin_function_on_o(reset_pin_function_on_o));
`default_nettype wire
